// ==== rtl/rtcalm_regs.svh ====
`ifndef RTCALM_REGS_SVH
`define RTCALM_REGS_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RTCALM_A_WDHR   8'h00
`define RTCALM_A_MINSEC 8'h04
`define RTCALM_A_CFG    8'h08
`define RTCALM_A_CAL    8'h0c
`define RTCALM_A_WIN    8'h10
`define RTCALM_A_STAT   8'h14
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTCALM_ENA_BIT  15
`define RTCALM_CHM_BIT  14
`define RTCALM_MSK_HI   13
`define RTCALM_MSK_LO   10
`define RTCALM_PTR_HI   9
`define RTCALM_PTR_LO   8
`define RTCALM_WDHR_MSK 16'h073f
`define RTCALM_MS_MSK   16'h7f7f
`define RTCALM_MD_MSK   16'h1f3f
`define RTCALM_CFG_MSK  16'hffff
`define RTCALM_PTR_MAX  2'h2
`define RTCALM_CAL_MUL  3'h2
`define RTCALM_FEB29    13'h0229
`endif

// ==== rtl/rtcalm_pkg.sv ====
package rtcalm_pkg;
  // mask codes
  typedef enum logic [3:0] {
    RTCALM_HALF = 4'h0, RTCALM_SEC = 4'h1, RTCALM_TENS = 4'h2, RTCALM_MIN = 4'h3,
    RTCALM_TENM = 4'h4, RTCALM_HOUR = 4'h5, RTCALM_DAY = 4'h6, RTCALM_WEEK = 4'h7,
    RTCALM_MON = 4'h8, RTCALM_YEAR = 4'h9
  } rtcalm_mask_t;
  // running time from the calendar counters
  typedef struct packed {
    logic        leap;
    logic [12:0] mthdy;
    logic [10:0] wdhr;
    logic [14:0] minsec;
  } rtcalm_time_t;
endpackage : rtcalm_pkg

// ==== rtl/rtcalm_top.sv ====
`timescale 1ns/10ps
`include "rtcalm_regs.svh"
module rtcalm_top (
  // clock, reset, enable
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 ce_in,
  // time base (same clock)
  input  wire logic                 half_tick_in,
  input  wire logic                 minute_tick_in,
  input  wire rtcalm_pkg::rtcalm_time_t now_in,
  // axi4-lite write
  input  wire logic [7:0]           awaddr_in,
  input  wire logic                 awvalid_in,
  output logic                      awready_out,
  input  wire logic [31:0]          wdata_in,
  input  wire logic [3:0]           wstrb_in,
  input  wire logic                 wvalid_in,
  output logic                      wready_out,
  output logic [1:0]                bresp_out,
  output logic                      bvalid_out,
  input  wire logic                 bready_in,
  // axi4-lite read
  input  wire logic [7:0]           araddr_in,
  input  wire logic                 arvalid_in,
  output logic                      arready_out,
  output logic [31:0]               rdata_out,
  output logic [1:0]                rresp_out,
  output logic                      rvalid_out,
  input  wire logic                 rready_in,
  // alarm and correction outputs
  output logic                      alarm_irq_out,
  output logic                      alarm_pulse_out,
  output logic                      cal_strobe_out,
  output logic signed [9:0]         cal_pulses_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] wdhr_q, minsec_q, mthdy_q, cfg_q, cal_q;
  logic        aw_q, w_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        wr_go;
  logic        fire;
  logic        match;
  logic [15:0] wv;

  // write-enable lives in the calibration register, bit 15
  wire wren = cal_q[15];

  // merge byte enables into a 16-bit register image
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // ----------------------------------------------------------------
  // axi4-lite write channel; address and data taken in either order
  // ----------------------------------------------------------------
  assign awready_out = ce_in && !aw_q && !bvalid_out;
  assign wready_out  = ce_in && !w_q && !bvalid_out;
  assign wr_go       = aw_q && w_q && !bvalid_out;
  assign wv          = wd_q[15:0];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0; ws_q <= 4'h0;
      bvalid_out <= 1'b0; bresp_out <= 2'h0;
    end else if (ce_in) begin
      if (awvalid_in && awready_out) begin
        aw_q <= 1'b1; awa_q <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_q <= 1'b1; wd_q <= wdata_in; ws_q <= wstrb_in;
      end
      if (wr_go) begin
        aw_q <= 1'b0; w_q <= 1'b0; bvalid_out <= 1'b1;
        // addresses above the status register answer slverr
        bresp_out <= (awa_q > `RTCALM_A_STAT) ? 2'h2 : 2'h0;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare value registers
  // ----------------------------------------------------------------
  // window access reaches pairs by pointer; pointer steps on upper byte
  logic [1:0] ptr;
  assign ptr = cfg_q[`RTCALM_PTR_HI:`RTCALM_PTR_LO];
  wire win_wr = wr_go && awa_q == `RTCALM_A_WIN;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdhr_q <= 16'h0; minsec_q <= 16'h0; mthdy_q <= 16'h0;
    end else if (ce_in && wr_go) begin
      if ((awa_q == `RTCALM_A_WDHR || (win_wr && ptr == 2'h1)) && wren)
        wdhr_q <= merge(wdhr_q, wd_q, ws_q) & `RTCALM_WDHR_MSK;
      if (awa_q == `RTCALM_A_MINSEC || (win_wr && ptr == 2'h0))
        minsec_q <= merge(minsec_q, wd_q, ws_q) & `RTCALM_MS_MSK;
      if (win_wr && ptr == `RTCALM_PTR_MAX && wren)
        mthdy_q <= merge(mthdy_q, wd_q, ws_q) & `RTCALM_MD_MSK;
    end
  end

  // ----------------------------------------------------------------
  // alarm match
  // ----------------------------------------------------------------
  always_comb begin
    logic s1, s10, m1, m10, h, wd, md;
    s1  = now_in.minsec[3:0] == minsec_q[3:0];
    s10 = now_in.minsec[6:4] == minsec_q[6:4];
    m1  = now_in.minsec[11:8] == minsec_q[11:8];
    m10 = now_in.minsec[14:12] == minsec_q[14:12];
    h   = now_in.wdhr[5:0] == wdhr_q[5:0];
    wd  = now_in.wdhr[10:8] == wdhr_q[10:8];
    md  = now_in.mthdy == mthdy_q[12:0];
    // a finer digit other than the weekday is always part of a coarser compare
    unique case (cfg_q[`RTCALM_MSK_HI:`RTCALM_MSK_LO])
      4'h0:    match = 1'b1;
      4'h1:    match = 1'b1;
      4'h2:    match = s1;
      4'h3:    match = s1 && s10;
      4'h4:    match = s1 && s10 && m1;
      4'h5:    match = s1 && s10 && m1 && m10;
      4'h6:    match = s1 && s10 && m1 && m10 && h;
      4'h7:    match = s1 && s10 && m1 && m10 && h && wd;
      4'h8:    match = s1 && s10 && m1 && m10 && h && now_in.mthdy[5:0] == mthdy_q[5:0];
      4'h9:    match = s1 && s10 && m1 && m10 && h && md &&
                       (mthdy_q[12:0] != `RTCALM_FEB29 || now_in.leap);
      default: match = 1'b0;  // reserved codes never fire
    endcase
  end

  // half-second tick toggles a phase so mask 0001 fires on whole seconds
  logic phase_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) phase_q <= 1'b0;
    else if (ce_in && half_tick_in) phase_q <= !phase_q;
  end

  wire second_ok = cfg_q[`RTCALM_MSK_HI:`RTCALM_MSK_LO] == 4'h0 || phase_q;
  assign fire = half_tick_in && cfg_q[`RTCALM_ENA_BIT] && match && second_ok;

  // ----------------------------------------------------------------
  // configuration, repeat count and enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q <= 16'h0;
    end else if (ce_in) begin
      if (wr_go && awa_q == `RTCALM_A_CFG)
        cfg_q <= merge(cfg_q, wd_q, ws_q) & `RTCALM_CFG_MSK;
      else if (win_wr && ws_q[1] && ptr != 2'h0)
        cfg_q[`RTCALM_PTR_HI:`RTCALM_PTR_LO] <= ptr - 2'h1;
      // the alarm wins over a concurrent software write
      if (fire) begin
        if (cfg_q[7:0] != 8'h00 || cfg_q[`RTCALM_CHM_BIT])
          cfg_q[7:0] <= cfg_q[7:0] - 8'h01;
        else
          cfg_q[`RTCALM_ENA_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration register and alarm outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_q <= 16'h0; cal_strobe_out <= 1'b0; cal_pulses_out <= 10'sh0;
      alarm_irq_out <= 1'b0; alarm_pulse_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_go && awa_q == `RTCALM_A_CAL)
        cal_q <= merge(cal_q, wd_q, ws_q);
      // signed step, four pulses each, once a minute
      cal_strobe_out <= minute_tick_in;
      if (minute_tick_in)
        cal_pulses_out <= $signed({cal_q[7], cal_q[7:0], 1'b0}) <<< 1;
      alarm_irq_out <= fire;
      if (fire) alarm_pulse_out <= !alarm_pulse_out;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign arready_out = ce_in && !rvalid_out;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rvalid_out <= 1'b0; rdata_out <= 32'h0; rresp_out <= 2'h0;
    end else if (ce_in) begin
      if (arvalid_in && arready_out) begin
        rvalid_out <= 1'b1; rresp_out <= 2'h0;
        unique case (araddr_in)
          `RTCALM_A_WDHR:   rdata_out <= {16'h0, wdhr_q};
          `RTCALM_A_MINSEC: rdata_out <= {16'h0, minsec_q};
          `RTCALM_A_CFG:    rdata_out <= {16'h0, cfg_q};
          `RTCALM_A_CAL:    rdata_out <= {16'h0, cal_q};
          `RTCALM_A_WIN:    rdata_out <= {16'h0, ptr == 2'h0 ? minsec_q :
                                          ptr == 2'h1 ? wdhr_q : ptr == 2'h2 ? mthdy_q : 16'h0};
          `RTCALM_A_STAT:   rdata_out <= {30'h0, alarm_pulse_out, phase_q};
          default: begin
            rdata_out <= 32'h0; rresp_out <= 2'h2;
          end
        endcase
      end else if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irq_follows: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && fire |=> alarm_irq_out) else $error("irq missed alarm");
  a_pulse_toggle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && fire |=> alarm_pulse_out != $past(alarm_pulse_out)) else $error("pulse stuck");
  a_last_disable: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && fire && cfg_q[7:0] == 8'h0 && !cfg_q[14] |=> !cfg_q[15]) else $error("not off");
  a_chime_wrap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && fire && cfg_q[7:0] == 8'h0 && cfg_q[14] |=> cfg_q[7:0] == 8'hff && cfg_q[15])
    else $error("chime did not wrap");
  a_count_dec: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && fire && cfg_q[7:0] != 8'h0 |=> cfg_q[7:0] == $past(cfg_q[7:0]) - 8'h1)
    else $error("count not decremented");
  a_wren_block: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !wren |=> $stable(wdhr_q)) else $error("weekday write without enable");
  a_wdhr_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wdhr_q[15:11] == 5'h0 && wdhr_q[7:6] == 2'h0) else $error("wdhr reserved bits");
  a_minsec_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !minsec_q[15] && !minsec_q[7]) else $error("minsec reserved bits");
  a_fire_tick: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fire |-> half_tick_in && cfg_q[15]) else $error("alarm off tick");
  a_cal_scale: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && minute_tick_in |=> cal_pulses_out == 10'($signed($past(cal_q[7:0])) * 4))
    else $error("calibration scale");
endmodule : rtcalm_top

// ==== bench/rtcalm_top_tb.sv ====
`timescale 1ns/10ps
`include "rtcalm_regs.svh"
module rtcalm_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic clk_in, rst_b_in, ce_in, half_tick_in, minute_tick_in;
  rtcalm_pkg::rtcalm_time_t now_in;
  logic [7:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, rd;
  logic [3:0] wstrb_in;
  logic awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, rs, smp_rresp_q;
  logic alarm_irq_out, alarm_pulse_out, cal_strobe_out;
  logic signed [9:0] cal_pulses_out;
  logic [4:0] smp_q;
  logic [31:0] smp_rdata_q;
  int error_cnt, checks_done, cyc, irq_cnt, n;
  logic [15:0] cal_v[2] = '{16'h80fd, 16'h8005};
  logic [9:0] cal_e[2] = '{10'h3f4, 10'h014};

  rtcalm_top uut (.*);

  // clock at 40 MHz
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // handshakes seen before the edge, so decisions at the edge never race the design
  always @(negedge clk_in) begin
    smp_q <= {awready_out, wready_out, bvalid_out, arready_out, rvalid_out};
    smp_rdata_q <= rdata_out;
    smp_rresp_q <= rresp_out;
    if (alarm_irq_out === 1'b1) irq_cnt++;
  end

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    awaddr_in <= a; wdata_in <= {16'h0000, d}; wstrb_in <= 4'hf;
    awvalid_in <= 1'b1; wvalid_in <= 1'b1; bready_in <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (smp_q[4]) awvalid_in <= 1'b0;
      if (smp_q[3]) wvalid_in <= 1'b0;
      if (smp_q[2]) begin
        done = 1'b1;
        bready_in <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    araddr_in <= a; arvalid_in <= 1'b1; rready_in <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (smp_q[1]) arvalid_in <= 1'b0;
      if (smp_q[0]) begin
        done = 1'b1;
        rready_in <= 1'b0;
        rd = smp_rdata_q;
        rs = smp_rresp_q;
      end
    end
  endtask : rd_reg

  // half-second ticks, each followed by room for the alarm to land
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk_in) half_tick_in <= 1'b1;
      @(posedge clk_in) half_tick_in <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask : ticks

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_in = 1'b0; ce_in = 1'b1; half_tick_in = 1'b0; minute_tick_in = 1'b0;
    now_in = '0; awaddr_in = 8'h00; araddr_in = 8'h00; wdata_in = 32'h0; wstrb_in = 4'h0;
    awvalid_in = 1'b0; wvalid_in = 1'b0; bready_in = 1'b0; arvalid_in = 1'b0;
    rready_in = 1'b0; irq_cnt = 0;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // weekday/hours writes obey the write enable; reserved bits read zero
    wr(`RTCALM_A_CAL, 16'h8000);
    wr(`RTCALM_A_WDHR, 16'h0312);
    wr(`RTCALM_A_CAL, 16'h0000);
    wr(`RTCALM_A_WDHR, 16'h0456);
    rd_reg(`RTCALM_A_WDHR);
    chk("wdhr locked", 32'h0312, rd);
    wr(`RTCALM_A_CAL, 16'h8000);
    wr(`RTCALM_A_WDHR, 16'hffff);
    rd_reg(`RTCALM_A_WDHR);
    chk("wdhr fields", 32'h073f, rd);
    wr(`RTCALM_A_MINSEC, 16'hffff);
    rd_reg(`RTCALM_A_MINSEC);
    chk("minsec fields", 32'h7f7f, rd);
    rd_reg(8'h40);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    // signed calibration applied four pulses a step, once per minute
    for (int i = 0; i < 2; i++) begin
      wr(`RTCALM_A_CAL, cal_v[i]);
      @(posedge clk_in) minute_tick_in <= 1'b1;
      @(posedge clk_in) minute_tick_in <= 1'b0;
      // look after the launching edge so the strobe is settled
      @(negedge clk_in);
      n = 0;
      while (cal_strobe_out !== 1'b1 && n < 8) begin
        @(negedge clk_in);
        n++;
      end
      chk("cal strobe", 32'h1, {31'h0, cal_strobe_out});
      chk("cal pulses", {22'h0, cal_e[i]}, {22'h0, cal_pulses_out});
    end
    // half-second mask, two repeats: three alarms then self-disable
    irq_cnt = 0;
    wr(`RTCALM_A_CFG, 16'h8002);
    ticks(5);
    chk("repeat alarms", 32'h3, irq_cnt);
    rd_reg(`RTCALM_A_CFG);
    chk("enable cleared", 32'h0, {31'h0, rd[15]});
    chk("pulse level", 32'h1, {31'h0, alarm_pulse_out});
    // chime: count wraps from 00 to ff and the alarm stays on
    irq_cnt = 0;
    wr(`RTCALM_A_CFG, 16'hc000);
    ticks(3);
    chk("chime alarms", 32'h3, irq_cnt);
    rd_reg(`RTCALM_A_CFG);
    chk("chime count", 32'hc0fd, rd & 32'hc0ff);
    wr(`RTCALM_A_CFG, 16'h0000);
    chk("pulse level", 32'h0, {31'h0, alarm_pulse_out});
    // daily mask: hours, minutes and seconds compared, weekday ignored
    irq_cnt = 0;
    wr(`RTCALM_A_WDHR, 16'h0612);
    wr(`RTCALM_A_MINSEC, 16'h3456);
    now_in.wdhr <= 11'h012;
    now_in.minsec <= 15'h3457;
    wr(`RTCALM_A_CFG, 16'h9800);
    ticks(2);
    chk("day mismatch", 32'h0, irq_cnt);
    now_in.minsec <= 15'h3456;
    ticks(2);
    chk("day single", 32'h1, irq_cnt);
    rd_reg(`RTCALM_A_CFG);
    chk("enable cleared", 32'h0, {31'h0, rd[15]});
    chk("pulse level", 32'h1, {31'h0, alarm_pulse_out});
    // window pointer: month/day pair first, then steps down to weekday/hours
    wr(`RTCALM_A_CFG, 16'h0200);
    wr(`RTCALM_A_WIN, 16'h0229);
    rd_reg(`RTCALM_A_CFG);
    chk("pointer step", 32'h0100, rd & 32'h0300);
    rd_reg(`RTCALM_A_WIN);
    chk("window pair", 32'h0612, rd);
    // yearly mask on february 29 only matches in a leap year
    irq_cnt = 0;
    now_in.mthdy <= 13'h0229;
    now_in.leap <= 1'b0;
    wr(`RTCALM_A_CFG, 16'ha400);
    ticks(2);
    chk("year no leap", 32'h0, irq_cnt);
    now_in.leap <= 1'b1;
    ticks(2);
    chk("year leap", 32'h1, irq_cnt);
    give_verdict();
  end
endmodule : rtcalm_top_tb
